// *** rtl/bcvc_defines.vh ***
/*
 Boot configuration vector capture: register offsets, field positions, reset values.
 Assumes a classic Wishbone slave with 32-bit data and byte addresses.
*/
`ifndef BCVC_DEFINES_VH
`define BCVC_DEFINES_VH

// Register byte offsets
`define BCVC_ADDR_STATUS      8'h00
`define BCVC_ADDR_PORT_CLOCKING_MODE_STRAP     8'h04
`define BCVC_ADDR_SWITCH_CONTROL       8'h08
`define BCVC_ADDR_EFFECTIVE   8'h0C

// Status field positions
`define BCVC_ST_FSEL          0
`define BCVC_ST_PORT_CLOCKING_MODE_STRAP_LO    1
`define BCVC_ST_MERGE_LO      3
`define BCVC_ST_HOLD          9
`define BCVC_ST_SADDR_LO      10
`define BCVC_ST_MODE_LO       12

// Switch control field positions
`define BCVC_CTL_HOLD         0
`define BCVC_CTL_HALTED       1

// Effective view field positions
`define BCVC_EF_PORT_CLOCKING_MODE_STRAP_LO    0
`define BCVC_EF_FREQ_125      2
`define BCVC_EF_SLAVE_ADDR_LO 3

// Widths
`define BCVC_MERGE_W          6
`define BCVC_VEC_W            16

// Reset values
`define BCVC_RST_VEC          16'h0000

// Synchroniser depth
`define BCVC_SYNC_STAGES      2

`endif

// *** rtl/bcvc_sync.v ***
/*
 Two-flop synchroniser for a bus of asynchronous pins.
 Assumes one clock domain; first stage is read only by the second.
*/
`timescale 1ns/10ps
module bcvc_sync #(
	parameter W = 1
) (
	input  wire         clk,
	input  wire         reset_n,
	input  wire [W-1:0] async_in,
	output wire [W-1:0] sync_out
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q <= {W{1'b0}};
			sync_q <= {W{1'b0}};
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;
endmodule // bcvc_sync

// *** rtl/bcvc_top.v ***
/*
 Boot configuration vector capture: samples straps at global reset release,
 keeps a raw status view, allows clock-mode and hold overrides, holds the
 switch in reset while a hold is pending. Wishbone classic register slave.
 Assumes straps and global_reset_n are asynchronous board pins; reset_n is
 the core reset on clk.
*/
// Decided for this implementation: the placing of the registers and the Wishbone register port.
// Functional notes
// R1: Keep captured straps in readable status register
// R2: Only clock mode and hold overridable later
// R3: Reference clock select from strap, no override
// R4: Clock-mode strap seeds mode; register write replaces
// R5: Six merge straps fixed, merge port pairs
// R6: Hold strap keeps device in reset, SMBus live
// R7: Leave hold only when control bit cleared
// R8: Slave address bits 2,1 from straps only
// R9: Operating mode from four-bit strap, no override
// R10: Straps ignored outside fundamental reset
// R11: Capture straps at global reset negation
// R12: Select gives 100 MHz or 125 MHz reference
// R13: Status always shows raw captured values
`timescale 1ns/10ps
`include "bcvc_defines.vh"
module bcvc_top (
	input  wire        clk,
	input  wire        reset_n,
	input  wire        global_reset_n,
	input  wire        refclk_freq_select,
	input  wire [1:0]  port_clocking_mode_strap,
	input  wire        merge_ports_0_1,
	input  wire        merge_ports_2_3,
	input  wire        merge_ports_4_5,
	input  wire        merge_ports_6_7,
	input  wire        merge_ports_8_9,
	input  wire        merge_ports_12_13,
	input  wire        reset_hold_request,
	input  wire [1:0]  slave_smbus_addr_strap,
	input  wire [3:0]  switch_operating_mode,
	input  wire [7:0]  wb_adr_i,
	input  wire [31:0] wb_dat_i,
	input  wire [3:0]  wb_sel_i,
	input  wire        wb_we_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	output reg         switch_in_reset,
	output reg         smbus_active,
	output reg         refclk_is_125mhz,
	output reg  [1:0]  port_clock_mode,
	output reg  [5:0]  merge_enable,
	output reg  [7:0]  slave_smbus_addr,
	output reg  [3:0]  operating_mode,
	output reg         config_valid
);
	localparam VW = `BCVC_VEC_W;
	localparam MW = `BCVC_MERGE_W;

	// Switch sequencer states, one-hot
	localparam [2:0] ST_FUND = 3'h1;
	localparam [2:0] ST_HALT = 3'h2;
	localparam [2:0] ST_RUN  = 3'h4;

	wire [VW-1:0] raw_vec;
	wire [VW-1:0] vec_sync;
	wire          gr_sync;

	// Strap pins gathered in status bit order
	assign raw_vec = {switch_operating_mode, slave_smbus_addr_strap, reset_hold_request,
		merge_ports_12_13, merge_ports_8_9, merge_ports_6_7, merge_ports_4_5,
		merge_ports_2_3, merge_ports_0_1, port_clocking_mode_strap, refclk_freq_select};

	// Straps and global reset take equal two-flop paths
	bcvc_sync #(.W(VW)) u_vec_sync (
		.clk      (clk),
		.reset_n  (reset_n),
		.async_in (raw_vec),
		.sync_out (vec_sync)
	);

	bcvc_sync #(.W(1)) u_rst_sync (
		.clk      (clk),
		.reset_n  (reset_n),
		.async_in (global_reset_n),
		.sync_out (gr_sync)
	);

	reg          gr_prev_q;
	reg [VW-1:0] status_q;
	reg [1:0]    port_clocking_mode_strap_q;
	reg          hold_q;
	reg          captured_q;
	reg [2:0]    state_q;
	reg [2:0]    state_d;
	reg [31:0]   rd_d;
	wire         capture;
	wire         in_fund_reset;
	wire         wb_hit;
	wire         wb_write;
	wire         wr_port_clocking_mode_strap;
	wire         wr_switch_control;
	wire         sw_run;
	wire         sw_fund;

	// Rising edge of the synchronised global reset
	assign capture       = gr_sync & ~gr_prev_q; // R11
	assign in_fund_reset = ~gr_sync;

	// Classic Wishbone, one registered ack per request
	assign wb_hit     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wb_write   = wb_hit & wb_we_i & wb_sel_i[0];
	assign wr_port_clocking_mode_strap = wb_write & (wb_adr_i == `BCVC_ADDR_PORT_CLOCKING_MODE_STRAP); // R2
	assign wr_switch_control   = wb_write & (wb_adr_i == `BCVC_ADDR_SWITCH_CONTROL); // R2

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			gr_prev_q <= 1'b0;
		end else begin
			gr_prev_q <= gr_sync;
		end
	end

	// Raw captured vector, straps ignored between captures
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			status_q   <= `BCVC_RST_VEC;
			captured_q <= 1'b0;
		end else begin
			if (capture) begin
				status_q   <= vec_sync; // R1 R10 R13
				captured_q <= 1'b1;
			end else if (in_fund_reset) begin
				captured_q <= 1'b0;
			end
		end
	end

	// Overridable settings, capture beats a write
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			port_clocking_mode_strap_q <= 2'h0;
			hold_q    <= 1'b0;
		end else begin
			if (capture) begin
				port_clocking_mode_strap_q <= vec_sync[`BCVC_ST_PORT_CLOCKING_MODE_STRAP_LO +: 2]; // R4
				hold_q    <= vec_sync[`BCVC_ST_HOLD]; // R6
			end else if (!in_fund_reset) begin
				if (wr_port_clocking_mode_strap)
					port_clocking_mode_strap_q <= wb_dat_i[1:0]; // R4
				if (wr_switch_control)
					hold_q <= wb_dat_i[`BCVC_CTL_HOLD]; // R7
			end
		end
	end

	// Sequencer: fundamental reset, halted, running
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_FUND: begin
				if (!in_fund_reset && captured_q)
					state_d = hold_q ? ST_HALT : ST_RUN; // R6
			end
			ST_HALT: begin
				if (in_fund_reset || !captured_q)
					state_d = ST_FUND;
				else if (!hold_q)
					state_d = ST_RUN; // R7
			end
			ST_RUN: begin
				if (in_fund_reset || !captured_q)
					state_d = ST_FUND;
				else if (hold_q)
					state_d = ST_HALT;
			end
			default: begin
				state_d = ST_FUND;
			end
		endcase
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_FUND;
		end else begin
			state_q <= state_d;
		end
	end

	assign sw_run  = (state_d == ST_RUN);
	assign sw_fund = (state_d == ST_FUND);

	// Register read mux
	always @* begin
		rd_d = 32'h00000000;
		case (wb_adr_i)
			`BCVC_ADDR_STATUS: begin
				rd_d[VW-1:0] = status_q; // R1 R13
			end
			`BCVC_ADDR_PORT_CLOCKING_MODE_STRAP: begin
				rd_d[1:0] = port_clocking_mode_strap_q;
			end
			`BCVC_ADDR_SWITCH_CONTROL: begin
				rd_d[`BCVC_CTL_HOLD]   = hold_q;
				rd_d[`BCVC_CTL_HALTED] = switch_in_reset;
			end
			`BCVC_ADDR_EFFECTIVE: begin
				rd_d[`BCVC_EF_PORT_CLOCKING_MODE_STRAP_LO +: 2]    = port_clock_mode;
				rd_d[`BCVC_EF_FREQ_125]           = refclk_is_125mhz;
				rd_d[`BCVC_EF_SLAVE_ADDR_LO +: 2] = slave_smbus_addr[2:1];
			end
			default: begin
				rd_d = 32'h00000000;
			end
		endcase
	end

	// Bus response
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wb_hit;
			if (wb_hit)
				wb_dat_o <= rd_d;
		end
	end

	// Reset and bus status outputs
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			switch_in_reset <= 1'b1;
			smbus_active    <= 1'b0;
			config_valid    <= 1'b0;
		end else begin
			switch_in_reset <= ~sw_run; // R6 R7
			smbus_active    <= ~sw_fund; // R6
			config_valid    <= captured_q; // R1
		end
	end

	// Fixed settings follow the captured vector; port_clock_mode follows the overridable clock-mode register
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			refclk_is_125mhz <= 1'b0;
			port_clock_mode  <= 2'h0;
			merge_enable     <= 6'h00;
			slave_smbus_addr <= 8'h00;
			operating_mode   <= 4'h0;
		end else begin
			refclk_is_125mhz <= status_q[`BCVC_ST_FSEL]; // R3 R12
			port_clock_mode  <= port_clocking_mode_strap_q; // R4
			merge_enable     <= status_q[`BCVC_ST_MERGE_LO +: MW]; // R5
			slave_smbus_addr <= {5'h00, status_q[`BCVC_ST_SADDR_LO +: 2], 1'b0}; // R8
			operating_mode   <= status_q[`BCVC_ST_MODE_LO +: 4]; // R9
		end
	end
endmodule // bcvc_top

// *** sim/bcvc_board.sv ***
/* Board strap model: drives the strap pins from the picked value.
 Assumes the bench holds pick steady across each fundamental reset. */
`timescale 1ns/10ps
module bcvc_board (
	input  wire         clk,
	input  wire  [15:0] pick,
	output logic [15:0] pins
);
	always @(posedge clk) pins <= pick;
endmodule // bcvc_board

// *** sim/bcvc_chk_checker.sv ***
/* Checker on the ports of bcvc_top.
 Assumes one clock domain with reset_n as its async reset. */
`timescale 1ns/10ps
module bcvc_chk (
	input wire       clk,
	input wire       reset_n,
	input wire       global_reset_n,
	input wire       wb_cyc_i,
	input wire       wb_stb_i,
	input wire       wb_ack_o,
	input wire       switch_in_reset,
	input wire       smbus_active,
	input wire       config_valid,
	input wire [5:0] merge_enable
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	ack_one_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	ack_due_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
	ack_src_a: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i)) else $error("stray ack");
	fund_hold_a: assert property (!global_reset_n [*4] |-> switch_in_reset) else $error("run");
	cap_gate_a: assert property (!config_valid [*2] |-> switch_in_reset) else $error("early");
	strap_fix_a: assert property (global_reset_n [*8] |-> $stable(merge_enable)) else $error("leak");
	smb_live_a: assert property (global_reset_n [*8] ##0 config_valid |-> smbus_active) else $error("smb");
	hold_release_a: assert property ($fell(switch_in_reset) |-> config_valid && global_reset_n) else $error("rel");
	cover property ($fell(switch_in_reset));
	cover property ($rose(config_valid));
	cover property (wb_ack_o);
endmodule // bcvc_chk
bind bcvc_top bcvc_chk i_bcvc_chk (.clk(clk), .reset_n(reset_n), .global_reset_n(global_reset_n),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .switch_in_reset(switch_in_reset),
	.smbus_active(smbus_active), .config_valid(config_valid), .merge_enable(merge_enable));

// *** sim/bcvc_top_test.sv ***
/* Bench for bcvc_top: random straps, capture, overrides, hold release.
 Assumes bcvc_board on the straps and bcvc_chk bound in. */
`timescale 1ns/10ps
`define CHK(a,b) begin num_checks++; if ((a)!==(b)) begin fails++; $display("BAD %0t %h %h",$time,a,b); end end
module bcvc_top_test;
	logic clk=0, reset_n=0, grn=0, cyc=0, stb=0, we=0, ack, si, sa, f125, cv;
	logic [7:0] adr=0, sad;
	logic [31:0] dat=0, rd, dq;
	logic [15:0] v, pick=0, pins;
	logic [3:0] sel=0, om;
	logic [1:0] pcm;
	logic [5:0] me;
	int fails=0, num_checks=0;
	bcvc_board i_bcvc_board (.clk(clk), .pick(pick), .pins(pins));
	bcvc_top i_bcvc_top (.clk(clk), .reset_n(reset_n), .global_reset_n(grn), .refclk_freq_select(pins[0]),
		.port_clocking_mode_strap(pins[2:1]), .merge_ports_0_1(pins[3]), .merge_ports_2_3(pins[4]),
		.merge_ports_4_5(pins[5]), .merge_ports_6_7(pins[6]), .merge_ports_8_9(pins[7]),
		.merge_ports_12_13(pins[8]), .reset_hold_request(pins[9]), .slave_smbus_addr_strap(pins[11:10]),
		.switch_operating_mode(pins[15:12]), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_we_i(we),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dq), .wb_ack_o(ack), .switch_in_reset(si),
		.smbus_active(sa), .refclk_is_125mhz(f125), .port_clock_mode(pcm), .merge_enable(me),
		.slave_smbus_addr(sad), .operating_mode(om), .config_valid(cv));
	initial forever #4 clk = ~clk;
	function automatic [7:0] exp_addr(input [15:0] x);
		return {5'h00, x[11:10], 1'b0};
	endfunction
	task automatic wrap_up;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		{cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hF};
		do @(posedge clk); while (ack !== 1'b1 && ++n < 50);
		rd = dq;
		{cyc, stb} <= 2'b00;
		@(posedge clk);
		if (n >= 50) begin fails++; wrap_up; end
	endtask
	initial begin
		void'($urandom(28));
		repeat (10) @(posedge clk);
		reset_n <= 1;
		for (int k = 0; k < 4; k++) begin
			v = 16'($urandom);
			v[9] = k[0];
			pick <= v;
			grn <= 0;
			repeat (6) @(posedge clk);
			grn <= 1;
			repeat (8) @(posedge clk);
			`CHK({si, sa, cv}, {v[9], 2'h3})
			pick <= ~v;
			repeat (8) @(posedge clk);
			`CHK({me, om, sad, f125, pcm}, {v[8:3], v[15:12], exp_addr(v), v[0], v[2:1]})
			wb(1, 8'h04, {30'h0, ~v[2:1]});
			wb(1, 8'h00, 32'hFFFF);
			`CHK(pcm, ~v[2:1])
			wb(0, 8'h00, 32'h0);
			`CHK(rd, {16'h0, v})
			wb(0, 8'h0C, 32'h0);
			`CHK(rd, {27'h0, v[11:10], v[0], ~v[2:1]})
			wb(0, 8'h10, 32'h0);
			`CHK({rd, si}, {32'h0, v[9]})
			wb(0, 8'h08, 32'h0);
			`CHK(rd, {30'h0, v[9], v[9]})
			wb(1, 8'h08, 32'h0);
			repeat (3) @(posedge clk);
			`CHK(si, 1'b0)
		end
		reset_n <= 0;
		grn <= 0;
		@(posedge clk);
		`CHK({si, sa, cv, me}, 9'h100)
		reset_n <= 1;
		repeat (2) @(posedge clk);
		`CHK({si, sa, cv}, 3'h4)
		wrap_up;
	end
endmodule // bcvc_top_test
